// File: rtl/block_timebase.sv
`timescale 1ns/1ps
`default_nettype none

module block_timebase
    import cs_buffer_pkg::*;
#(
    parameter int SF_CLKS  = SUBFRAME_CLKS,
    parameter int SYNC_MIN = SYNC_MIN_CLKS
)
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       sync_listen,
    input  wire logic       sync_level,
    output timebase_t       tb
);

    // Counter widths below cap the subframe length and the sync filter length
    if (SF_CLKS < 4 || SF_CLKS > 128 || SYNC_MIN < 1 || SYNC_MIN > 7)
    begin
        $error("block_timebase: unsupported parameters");
    end

    typedef struct packed {
        logic [6:0] cyc;
        logic [8:0] sub;
        logic [2:0] high_cnt;
        logic       pending;
        timebase_t  out;
    } tb_state_t;

    tb_state_t st_ff;
    tb_state_t nxt_st;

    // ********************************************************
    // Subframe and block counting
    // ********************************************************
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.out.sf_tick = 1'b0;
        if (st_ff.cyc == 7'(SF_CLKS - 1))
        begin
            nxt_st.cyc = 7'h0;
            if (st_ff.pending && sync_listen)
                nxt_st.sub = 9'h0;
            else if (st_ff.sub == 9'(BLOCK_SUBFRAMES - 1))
                nxt_st.sub = 9'h0;
            else
                nxt_st.sub = st_ff.sub + 9'h1;
            nxt_st.pending = 1'b0;
            nxt_st.out.sf_tick = 1'b1;
            nxt_st.out.subframe = nxt_st.sub;
        end
        else
            nxt_st.cyc = st_ff.cyc + 7'h1;
        // Counts run from reset release, so devices released together stay aligned
        // Sync is filtered after the tick so a pulse ending on a tick is not lost
        if (sync_listen && sync_level)
        begin
            if (st_ff.high_cnt != 3'(SYNC_MIN))
                nxt_st.high_cnt = st_ff.high_cnt + 3'h1;
            if (st_ff.high_cnt == 3'(SYNC_MIN - 1))
                nxt_st.pending = 1'b1;
        end
        else
            nxt_st.high_cnt = 3'h0;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign tb = st_ff.out;

endmodule

`default_nettype wire

// File: rtl/cs_buffer_pkg.sv
package cs_buffer_pkg;

    // ********************************************************
    // Control port map
    // ********************************************************
    localparam logic [6:0] CTRL_OFFSET       = 7'h00;
    localparam logic [6:0] STATUS_OFFSET     = 7'h01;
    localparam logic [6:0] IDENT_OFFSET      = 7'h02;
    localparam logic [6:0] STAGE_CS_BASE     = 7'h20;
    localparam logic [6:0] STAGE_USER_BASE   = 7'h50;
    localparam logic [6:0] STAGE_USER_END    = 7'h7f;

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int         CTRL_OPERATE_BIT  = 0;
    localparam int         CTRL_INHIBIT_BIT  = 1;
    localparam int         CTRL_IRQ_EN_BIT   = 2;
    localparam int         STATUS_XFER_BIT   = 0;
    localparam int         IDENT_PART_LSB    = 4;
    localparam int         IDENT_REV_LSB     = 0;
    localparam logic [2:0] CTRL_RESET        = 3'h0;

    // ********************************************************
    // Buffer geometry and timebase
    // ********************************************************
    localparam int BUF_WORDS       = 24;
    localparam int WORD_BITS       = 16;
    localparam int BLOCK_SUBFRAMES = 384;
    localparam int SUBFRAME_CLKS   = 128;
    localparam int SYNC_MIN_CLKS   = 3;

    typedef logic [BUF_WORDS-1:0][WORD_BITS-1:0] block_buf_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cp_req_t;

    typedef struct packed {
        logic       sf_tick;
        logic [8:0] subframe;
    } timebase_t;

endpackage

// File: rtl/cs_buffer_top.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Reset low clears every register and buffer except bs_oe_n, which it sets to release the block start pin.
// - After reset the port works; writing 1 to operate starts transmission.
// - A readable register holds a 4-bit part code and 4-bit revision.
// - Timing starts deterministically from reset release so grouped devices align.
// - Storage holds 384 channel status bits and 384 user bits.
// - Two cascaded block buffers; blocks captured, retimed, then transmitted.
// - Staging is host read/write; transmit buffer only fed by block transfers.
// - Byte MSB goes out first; byte 0 at 20h is A channel pro flag.
// - Driven block start high in first subframe; received high 3 clocks restarts.
// - Staging is 24 words of 16 bits; status words A upper byte, B lower.
// - Inhibit bit stops transfers; enabled event flag signals each transfer.
module cs_buffer_top
    import cs_buffer_pkg::*;
#(
    parameter logic [3:0] PART_CODE = 4'h5, // Arbitrary value
    parameter logic [3:0] REV_CODE  = 4'h1  // Arbitrary value
)
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire cp_req_t    cp_req,
    output logic [7:0]      cp_rdata,
    output logic            cp_rvalid,
    input  wire logic       block_start_drive,
    input  wire logic       block_start_sync_i,
    output logic            block_start_sync_o,
    output logic            block_start_sync_oe_n,
    output logic            cs_bit,
    output logic            user_bit,
    output logic            bit_valid,
    output logic            transmitting,
    output logic            xfer_irq
);

    typedef struct packed {
        logic [2:0] ctrl;
        logic       xfer_flag;
        block_buf_t stage_cs;
        block_buf_t stage_user;
        block_buf_t tx_cs;
        block_buf_t tx_user;
        logic [7:0] rdata;
        logic       rvalid;
        logic       bs_o;
        logic       bs_oe_n;
        logic       cs;
        logic       usr;
        logic       valid;
        logic       run;
        logic       irq;
    } top_state_t;

    top_state_t st_ff;
    top_state_t nxt_st;
    timebase_t  tb;

    block_timebase #(
        .SF_CLKS  (SUBFRAME_CLKS),
        .SYNC_MIN (SYNC_MIN_CLKS)
    ) u_timebase (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .sync_listen (!block_start_drive),
        .sync_level  (block_start_sync_i),
        .tb          (tb)
    );

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [4:0] word_of(input logic [6:0] off);
        word_of = 5'(off[6:1]);
    endfunction

    function automatic logic read_bit(input block_buf_t buf_v, input logic [8:0] sf,
                                      input logic is_user);
        logic [4:0] w;
        logic [3:0] pos;
        w = 5'(sf[8:4]);
        // Status words interleave A/B per bit; user words send the upper byte, then the lower byte
        if (is_user)
            pos = 4'hf - sf[3:0];
        else
            pos = {~sf[0], 3'h7 - sf[3:1]};
        read_bit = buf_v[w][pos];
    endfunction

    function automatic logic is_cs_addr(input logic [6:0] a);
        is_cs_addr = a >= STAGE_CS_BASE && a < STAGE_USER_BASE;
    endfunction

    // The user area runs to the top of the 7-bit address space
    function automatic logic is_user_addr(input logic [6:0] a);
        is_user_addr = a >= STAGE_USER_BASE;
    endfunction

    // Even offsets hold the upper byte (A channel in status words), odd offsets the lower byte
    function automatic logic [7:0] byte_of(input logic [15:0] wd, input logic lane);
        byte_of = lane ? wd[7:0] : wd[15:8];
    endfunction

    // ********************************************************
    // Control port and buffer transfer
    // ********************************************************
    always_comb
    begin
        logic [4:0] w;
        logic       xfer;
        w = 5'h0;
        xfer = 1'b0;
        nxt_st = st_ff;
        nxt_st.rvalid = cp_req.rd;
        nxt_st.rdata = 8'h0;
        nxt_st.irq = 1'b0;

        if (cp_req.rd)
        begin
            if (cp_req.addr == CTRL_OFFSET)
                nxt_st.rdata = {5'h0, st_ff.ctrl};
            else if (cp_req.addr == STATUS_OFFSET)
                nxt_st.rdata = {7'h0, st_ff.xfer_flag};
            else if (cp_req.addr == IDENT_OFFSET)
                nxt_st.rdata = {PART_CODE, REV_CODE};
            else if (is_cs_addr(cp_req.addr))
            begin
                w = word_of(cp_req.addr - STAGE_CS_BASE);
                nxt_st.rdata = byte_of(st_ff.stage_cs[w], cp_req.addr[0]);
            end
            else if (is_user_addr(cp_req.addr))
            begin
                w = word_of(cp_req.addr - STAGE_USER_BASE);
                nxt_st.rdata = byte_of(st_ff.stage_user[w], cp_req.addr[0]);
            end
        end

        if (cp_req.wr)
        begin
            if (cp_req.addr == CTRL_OFFSET)
                nxt_st.ctrl = cp_req.wdata[2:0];
            else if (cp_req.addr == STATUS_OFFSET && cp_req.wdata[STATUS_XFER_BIT])
                nxt_st.xfer_flag = 1'b0;
            else if (is_cs_addr(cp_req.addr))
            begin
                w = word_of(cp_req.addr - STAGE_CS_BASE);
                if (cp_req.addr[0])
                    nxt_st.stage_cs[w][7:0] = cp_req.wdata;
                else
                    nxt_st.stage_cs[w][15:8] = cp_req.wdata;
            end
            else if (is_user_addr(cp_req.addr))
            begin
                w = word_of(cp_req.addr - STAGE_USER_BASE);
                if (cp_req.addr[0])
                    nxt_st.stage_user[w][7:0] = cp_req.wdata;
                else
                    nxt_st.stage_user[w][15:8] = cp_req.wdata;
            end
        end

        // A transfer takes the staging contents as they stood before this cycle's write
        // Transfers follow the timebase even while stopped, so the host can pace writes
        xfer = tb.sf_tick && tb.subframe == 9'h0 && !st_ff.ctrl[CTRL_INHIBIT_BIT];
        if (xfer)
        begin
            nxt_st.tx_cs = st_ff.stage_cs;
            nxt_st.tx_user = st_ff.stage_user;
            nxt_st.xfer_flag = 1'b1;
            nxt_st.irq = st_ff.ctrl[CTRL_IRQ_EN_BIT];
        end

        // ********************************************************
        // Serial bit source and block start pin
        // ********************************************************
        nxt_st.run = st_ff.ctrl[CTRL_OPERATE_BIT];
        nxt_st.valid = 1'b0;
        if (tb.sf_tick && st_ff.run)
        begin
            nxt_st.cs = read_bit(nxt_st.tx_cs, tb.subframe, 1'b0);
            nxt_st.usr = read_bit(nxt_st.tx_user, tb.subframe, 1'b1);
            nxt_st.valid = 1'b1;
        end
        else if (!st_ff.run)
        begin
            nxt_st.cs = 1'b0;
            nxt_st.usr = 1'b0;
        end
        // Pin stays released while idle so a stopped device never fights the group
        nxt_st.bs_oe_n = !(block_start_drive && st_ff.run);
        if (tb.sf_tick)
            nxt_st.bs_o = tb.subframe == 9'h0;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_ff <= '0;
            st_ff.ctrl <= CTRL_RESET;
            st_ff.bs_oe_n <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    assign cp_rdata = st_ff.rdata;
    assign cp_rvalid = st_ff.rvalid;
    assign block_start_sync_o = st_ff.bs_o;
    assign block_start_sync_oe_n = st_ff.bs_oe_n;
    assign cs_bit = st_ff.cs;
    assign user_bit = st_ff.usr;
    assign bit_valid = st_ff.valid;
    assign transmitting = st_ff.run;
    assign xfer_irq = st_ff.irq;

endmodule

`default_nettype wire

// File: test/cp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host on the control port
// ****
module cp_host_model
    import cs_buffer_pkg::*;
(
    input  wire logic sys_clk,
    output cp_req_t   req
);
    initial req = '0;
    // Released address and data lines show the inverse so a stale value is never read as good
    task automatic access(input logic [6:0] a, input logic [7:0] d, input logic w);
        @(posedge sys_clk);
        #1 req = '{a, d, w, !w};
        @(posedge sys_clk);
        #1 req = '{~a, ~d, 1'b0, 1'b0};
    endtask
endmodule
`default_nettype wire

// File: test/cs_buffer_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks
// ****
module cs_buffer_props
    import cs_buffer_pkg::*;
#(
    parameter logic [3:0] PART_CODE = 4'h5,
    parameter logic [3:0] REV_CODE  = 4'h1
)
(
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire cp_req_t    cp_req,
    input wire logic [7:0] cp_rdata,
    input wire logic       cp_rvalid,
    input wire logic       block_start_drive,
    input wire logic       block_start_sync_o,
    input wire logic       block_start_sync_oe_n,
    input wire logic       cs_bit,
    input wire logic       user_bit,
    input wire logic       bit_valid,
    input wire logic       transmitting,
    input wire logic       xfer_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_ident_rd;
        cp_req.rd && cp_req.addr == IDENT_OFFSET;
    endsequence
    sequence s_block_head;
        bit_valid && block_start_sync_o;
    endsequence
    a_read_answer: assert property (cp_req.rd |=> cp_rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property (cp_rvalid |-> $past(cp_req.rd))
        else $error("read data without a read");
    a_ident_value: assert property (s_ident_rd |=> cp_rdata == {PART_CODE, REV_CODE})
        else $error("identity value wrong");
    a_idle_stream: assert property (!transmitting [*2] |-> !bit_valid)
        else $error("bit stream while stopped");
    a_oe_cause: assert property (!block_start_sync_oe_n |-> $past(block_start_drive))
        else $error("block start driven while listening");
    a_irq_head: assert property (xfer_irq && $past(transmitting) |-> s_block_head)
        else $error("transfer event off block head");
    a_bit_period: assert property (bit_valid && transmitting
        |-> ##128 (bit_valid || !transmitting))
        else $error("subframe period wrong");
    a_sync_stands: assert property ($rose(block_start_sync_o) && $past(transmitting)
        |-> bit_valid ##1 block_start_sync_o [*8])
        else $error("block start pulse wrong");
    a_bits_hold: assert property (!bit_valid && $past(transmitting) && transmitting
        |-> $stable(cs_bit) && $stable(user_bit))
        else $error("bits moved between subframes");
endmodule
bind cs_buffer_top cs_buffer_props #(.PART_CODE(PART_CODE), .REV_CODE(REV_CODE)) u_props (
    .sys_clk(sys_clk), .resetn(resetn), .cp_req(cp_req), .cp_rdata(cp_rdata),
    .cp_rvalid(cp_rvalid), .block_start_drive(block_start_drive),
    .block_start_sync_o(block_start_sync_o), .block_start_sync_oe_n(block_start_sync_oe_n),
    .cs_bit(cs_bit), .user_bit(user_bit), .bit_valid(bit_valid),
    .transmitting(transmitting), .xfer_irq(xfer_irq));
`default_nettype wire

// File: test/cs_buffer_top_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module cs_buffer_top_test;
    import cs_buffer_pkg::*;
    logic       sys_clk = 0, resetn = 0, drive = 0, sync_in = 0, armed = 0;
    cp_req_t    cp_req;
    logic [7:0] cp_rdata, stage [96], tx [96];
    logic       cp_rvalid, sync_o, oe_n, cs_bit, user_bit, bit_valid, transmitting, xfer_irq;
    logic [7:0] exp_rd [$];
    logic [3:0] exp_bit [$];
    int         bad_count = 0, n_tests = 0, cycles = 0;
    always #5 sys_clk = ~sys_clk;
    cp_host_model host (.sys_clk(sys_clk), .req(cp_req));
    // Identity values are arbitrary
    cs_buffer_top #(.PART_CODE(4'ha), .REV_CODE(4'h3)) DUT (
        .sys_clk(sys_clk), .resetn(resetn), .cp_req(cp_req), .cp_rdata(cp_rdata),
        .cp_rvalid(cp_rvalid), .block_start_drive(drive), .block_start_sync_i(sync_in),
        .block_start_sync_o(sync_o), .block_start_sync_oe_n(oe_n), .cs_bit(cs_bit),
        .user_bit(user_bit), .bit_valid(bit_valid), .transmitting(transmitting),
        .xfer_irq(xfer_irq));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        check("reads left", 8'(exp_rd.size()), 8'h00);
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        host.access(a, 8'h00, 1'b0);
    endtask
    // Subframe 0 follows the next tick after a three clock block start pulse
    task automatic new_block(input int n, input logic irq);
        @(posedge sys_clk iff bit_valid);
        #1 sync_in = 1;
        repeat (3) @(posedge sys_clk);
        #1 sync_in = 0;
        for (int s = 0; s < n; s++)
            exp_bit.push_back({tx[2*(s/16)+s%2][7-(s/2)%8], tx[48+2*(s/16)+(s/8)%2][7-s%8],
                               irq && s == 0, s == 0});
        armed = 1;
        wait (exp_bit.size() == 0);
        armed = 0;
    endtask
    always @(posedge sys_clk)
    begin
        if (cp_rvalid)
            check("rdata", cp_rdata, exp_rd.pop_front());
        if (bit_valid && armed && exp_bit.size() > 0)
            check("stream", {cs_bit, user_bit, xfer_irq, sync_o}, exp_bit.pop_front());
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    initial
    begin
        void'($urandom(97));
        repeat (5) @(posedge sys_clk);
        #1 resetn = 1;
        check("oe_n", 8'(oe_n), 8'h01);
        check("run", 8'(transmitting), 8'h00);
        rd(CTRL_OFFSET, {5'h00, CTRL_RESET});
        rd(STATUS_OFFSET, 8'h00);
        host.access(IDENT_OFFSET, 8'h00, 1'b1);
        rd(IDENT_OFFSET, 8'ha3);
        rd(7'h03, 8'h00);
        for (int i = 0; i < 96; i++)
        begin
            stage[i] = 8'($urandom);
            host.access(STAGE_CS_BASE + 7'(i), stage[i], 1'b1);
        end
        for (int i = 0; i < 96; i++)
            rd(STAGE_CS_BASE + 7'(i), stage[i]);
        host.access(CTRL_OFFSET, 8'h05, 1'b1);
        tx = stage;
        new_block(48, 1'b1);
        check("run", 8'(transmitting), 8'h01);
        rd(STATUS_OFFSET, 8'h01);
        host.access(STATUS_OFFSET, 8'h01, 1'b1);
        rd(STATUS_OFFSET, 8'h00);
        host.access(CTRL_OFFSET, 8'h07, 1'b1);
        host.access(STAGE_CS_BASE, ~stage[0], 1'b1);
        new_block(16, 1'b0);
        rd(STAGE_CS_BASE, ~stage[0]);
        rd(STATUS_OFFSET, 8'h00);
        @(posedge sys_clk);
        #1 drive = 1;
        repeat (2) @(posedge sys_clk);
        #1 check("oe_n", 8'(oe_n), 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
